//--- ps_sequencer.sv
// Operation
// [RULE1] Four non-overlapping phase clocks from system clock form one instruction cycle.
// [RULE2] Counter increments and fetch happen at phase one; later phases execute.
// [RULE3] Fetch overlaps execute; counter-changing instructions cost one extra cycle.
// [RULE4] With RC oscillator selected, oscillator pin carries phase one, 1:3 duty.
// [RULE5] Counter advances by one unless a non-consecutive transfer is demanded.
// [RULE6] Only low counter byte is accessible; writing it branches within page.
// [RULE7] Branch through low byte write inserts a dummy cycle for prefetch.
// [RULE8] Met skip discards fetched instruction, runs dummy cycle, counter plus two.
// [RULE9] Six-level return stack holds counter values only, invisible to software.
// [RULE10] Call or interrupt acknowledge pushes the counter onto the stack.
// [RULE11] Subroutine or interrupt return pops and loads all twelve counter bits.
// [RULE12] After reset the stack index is at top and counter is zero.
// [RULE13] Full stack latches interrupt request but withholds acknowledge until a return.
// [RULE14] Call on full stack still executes and overflows the stack.
// [RULE15] Vectors: reset zero, external 004, timer zero 008, timer one 00C.
// [RULE16] Jumps, calls, interrupts, reset load target; jump and call give twelve bits.
// [RULE17] Eight-bit ALU writes result to target register and updates status flags.
// [RULE18] ALU offers add, subtract, decimal adjust, logic, complement, rotates, inc, dec.
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module ps_sequencer
  import ps_pkg::*;
#(
  parameter int DEPTH = STACK_LEVELS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [11:0] pmem_addr,
  input wire logic [14:0] pmem_data,
  output logic [7:0] data_addr,
  input wire logic [7:0] data_rdata,
  output logic [7:0] data_wdata,
  output logic data_we,
  input wire logic irq_ext,
  input wire logic irq_t0,
  input wire logic irq_t1,
  output logic int_ack,
  output logic [3:0] instruction_phase_clocks,
  output logic oscillator_output_pin
);
  localparam int SP_W = $clog2(DEPTH + 1);
  localparam logic [SP_W-1:0] SP_FULL = SP_W'(DEPTH);
  localparam logic [SP_W-1:0] SP_ONE = SP_W'(1);

  ps_phase_type phase_r;
  logic [3:0] phase_oh_r;
  logic osc_r;
  logic [11:0] pc_r;
  logic [14:0] ir_r;
  logic dummy_r;
  logic [7:0] acc_r;
  ps_flags_type flags_r;
  logic [7:0] ctrl_r;
  logic [2:0] pend_r;
  logic pcl_pend_r;
  logic [7:0] pcl_val_r;
  logic [11:0] stack_r [DEPTH];
  logic [SP_W-1:0] stack_index;
  logic ack_r;
  logic [31:0] dat_r;
  logic [7:0] wdata_r;
  logic we_r;
  logic [7:0] waddr_r;
  logic iack_r;

  logic cycle_end, exec, run, full;
  logic [1:0] cls;
  logic [2:0] sub;
  logic dest_mem;
  ps_alu_op_type op;
  logic [7:0] imm, opnd, bb, res, adj;
  logic [8:0] sum9;
  logic [4:0] aux5;
  logic cin, is_arith;
  ps_flags_type flg_nxt;
  logic is_ret, is_interrupt_return_op, is_skip, pcl_instr, pcl_take;
  logic branch, skip, take_irq, push, pop;
  logic [11:0] target, pop_val, vector;
  logic [2:0] irq_req, irq_clr;
  logic bus_wr;

  assign run = ctrl_r[CTRL_RUN];
  assign full = stack_index == SP_FULL;
  assign cycle_end = phase_r == PH_T4;
  assign exec = cycle_end && run && !dummy_r;
  assign cls = ir_r[F_CLS_HI:F_CLS_LO];
  assign sub = ir_r[F_OP_LO+2:F_OP_LO];
  assign dest_mem = ir_r[F_DEST];
  assign op = ps_alu_op_type'(ir_r[F_OP_HI:F_OP_LO]);
  assign imm = ir_r[7:0];
  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r && wb_sel_i[0];

  // Phase sequencer; phase counter and one-hot clocks kept as twin registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= PH_T1;
      phase_oh_r <= 4'h1;
    end else begin
      phase_r <= ps_phase_type'(phase_r + 2'h1); // RULE1
      phase_oh_r <= {phase_oh_r[2:0], phase_oh_r[3]}; // RULE1
    end
  end

  // Pin follows phase one only when the RC oscillator frees it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      osc_r <= 1'b0;
    end else begin
      osc_r <= ctrl_r[CTRL_RCSEL] && phase_oh_r[3]; // RULE4
    end
  end

  // Eight-bit arithmetic unit
  always_comb begin
    opnd = dest_mem ? data_rdata : imm;
    is_arith = op inside {ALU_SUB, ALU_SBC};
    bb = is_arith ? ~opnd : opnd;
    cin = (op == ALU_ADC || op == ALU_SBC) ? flags_r.c : is_arith;
    sum9 = {1'b0, acc_r} + {1'b0, bb} + {8'h00, cin};
    aux5 = {1'b0, acc_r[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
    adj = 8'h00;
    flg_nxt = flags_r;
    res = 8'h00;
    case (op) // RULE18
      ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
        res = sum9[7:0];
        flg_nxt.c = sum9[8]; // RULE17
        flg_nxt.ac = aux5[4];
        flg_nxt.ov = (acc_r[7] == bb[7]) && (res[7] != acc_r[7]);
      end
      ALU_DAA: begin
        if (acc_r[3:0] > BCD_MAX || flags_r.ac) adj = adj | BCD_LO;
        if (acc_r[7:4] > BCD_MAX || flags_r.c) adj = adj | BCD_HI;
        sum9 = {1'b0, acc_r} + {1'b0, adj};
        res = sum9[7:0];
        flg_nxt.c = flags_r.c || sum9[8];
      end
      ALU_AND: res = acc_r & opnd;
      ALU_OR: res = acc_r | opnd;
      ALU_XOR: res = acc_r ^ opnd;
      ALU_CPL: res = ~opnd;
      ALU_RR: res = {opnd[0], opnd[7:1]};
      ALU_RRC: begin
        res = {flags_r.c, opnd[7:1]};
        flg_nxt.c = opnd[0];
      end
      ALU_RL: res = {opnd[6:0], opnd[7]};
      ALU_RLC: begin
        res = {opnd[6:0], flags_r.c};
        flg_nxt.c = opnd[7];
      end
      ALU_INC: res = opnd + 8'h01;
      ALU_DEC: res = opnd - 8'h01;
      default: res = opnd;
    endcase
    // Rotates leave zero flag alone
    if (!(op inside {ALU_RR, ALU_RRC, ALU_RL, ALU_RLC})) flg_nxt.z = res == 8'h00; // RULE17
  end

  // Program flow decisions for the instruction finishing this cycle
  always_comb begin
    is_ret = cls == CLS_CTRL && (sub == SUB_RET || sub == SUB_INTERRUPT_RETURN_OP);
    is_interrupt_return_op = cls == CLS_CTRL && sub == SUB_INTERRUPT_RETURN_OP;
    is_skip = cls == CLS_CTRL && ((sub == SUB_SZ && acc_r == 8'h00) || (sub == SUB_SNZ && acc_r != 8'h00));
    pcl_instr = cls == CLS_CTRL && (sub == SUB_PCL || sub == SUB_PCLA);
    pcl_take = pcl_pend_r && !(cls == CLS_JMP || cls == CLS_CALL || is_ret || pcl_instr);
    pop_val = (stack_index == '0) ? stack_r[0] : stack_r[stack_index - SP_ONE];
    target = pc_r;
    if (cls == CLS_JMP || cls == CLS_CALL) begin
      target = ir_r[11:0]; // RULE16
    end else if (is_ret) begin
      target = pop_val; // RULE11
    end else if (pcl_instr) begin
      target = {pc_r[11:8], (sub == SUB_PCL) ? imm : acc_r}; // RULE6
    end else if (pcl_take) begin
      target = {pc_r[11:8], pcl_val_r}; // RULE6
    end
    branch = exec && (cls == CLS_JMP || cls == CLS_CALL || is_ret || pcl_instr || pcl_take);
    skip = exec && is_skip;
    irq_req = pend_r & ctrl_r[CTRL_EN_HI:CTRL_EN_LO];
    // Full stack blocks acknowledge, the request stays latched
    take_irq = exec && !branch && !skip && ctrl_r[CTRL_GIE] && irq_req != 3'h0 && !full; // RULE13
    irq_clr = 3'h0;
    vector = VEC_RESET;
    if (irq_req[0]) begin
      vector = VEC_EXT; // RULE15
      irq_clr = 3'h1;
    end else if (irq_req[1]) begin
      vector = VEC_T0; // RULE15
      irq_clr = 3'h2;
    end else if (irq_req[2]) begin
      vector = VEC_T1; // RULE15
      irq_clr = 3'h4;
    end
    if (!take_irq) irq_clr = 3'h0;
    push = (branch && cls == CLS_CALL) || take_irq; // RULE10
    pop = branch && is_ret;
  end

  // Counter, instruction register and dummy cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pc_r <= VEC_RESET; // RULE12
      ir_r <= {CLS_CTRL, 1'b0, 1'b0, SUB_NOP, 8'h00};
      dummy_r <= 1'b0;
    end else if (cycle_end && run) begin
      if (dummy_r) begin
        ir_r <= pmem_data; // RULE7
        pc_r <= pc_r + PC_ONE;
        dummy_r <= 1'b0;
      end else if (branch) begin
        pc_r <= target; // RULE3
        dummy_r <= 1'b1; // RULE7
      end else if (skip) begin
        pc_r <= pc_r + PC_ONE; // RULE8
        dummy_r <= 1'b1; // RULE8
      end else if (take_irq) begin
        pc_r <= vector; // RULE16
        dummy_r <= 1'b1;
      end else begin
        ir_r <= pmem_data; // RULE2
        pc_r <= pc_r + PC_ONE; // RULE5
      end
    end
  end

  // Return stack; a push when full overwrites the top slot
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stack_index <= '0; // RULE12
      for (int i = 0; i < DEPTH; i++) stack_r[i] <= 12'h000;
    end else if (push) begin
      if (full) begin
        stack_r[DEPTH-1] <= pc_r; // RULE14
      end else begin
        stack_r[stack_index] <= pc_r; // RULE9
        stack_index <= stack_index + SP_ONE;
      end
    end else if (pop && stack_index != '0) begin
      stack_index <= stack_index - SP_ONE; // RULE11
    end
  end

  // Accumulator and flags; ALU result beats a bus write in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= ACC_RST;
      flags_r <= '0;
    end else if (exec && cls == CLS_ALU) begin
      flags_r <= flg_nxt; // RULE17
      if (!dest_mem) acc_r <= res; // RULE17
    end else if (bus_wr && wb_adr_i == OFS_ACC) begin
      acc_r <= wb_dat_i[7:0];
    end
  end

  // Memory result port
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wdata_r <= 8'h00;
      waddr_r <= 8'h00;
      we_r <= 1'b0;
    end else begin
      we_r <= exec && cls == CLS_ALU && dest_mem;
      if (exec && cls == CLS_ALU && dest_mem) begin
        wdata_r <= res; // RULE17
        waddr_r <= ir_r[7:0]; // RULE17
      end
    end
  end

  // Interrupt latches; a new request wins over its acknowledge clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 3'h0;
      iack_r <= 1'b0;
    end else begin
      pend_r <= (pend_r & ~irq_clr) | {irq_t1, irq_t0, irq_ext}; // RULE13
      iack_r <= take_irq; // RULE10
    end
  end

  // Control register; acknowledge masks, interrupt return unmasks
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
    end else begin
      if (bus_wr && wb_adr_i == OFS_CTRL) ctrl_r <= wb_dat_i[7:0];
      if (take_irq) ctrl_r[CTRL_GIE] <= 1'b0;
      if (branch && is_interrupt_return_op) ctrl_r[CTRL_GIE] <= 1'b1;
    end
  end

  // Bus low byte write becomes a branch at the next executed cycle end whose instruction is not itself a jump, call, return or low byte write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pcl_pend_r <= 1'b0;
      pcl_val_r <= 8'h00;
    end else if (bus_wr && wb_adr_i == OFS_PCL) begin
      pcl_pend_r <= 1'b1; // RULE6
      pcl_val_r <= wb_dat_i[7:0];
    end else if (pcl_take && branch) begin
      pcl_pend_r <= 1'b0;
    end
  end

  // Wishbone slave; one registered ack after a single wait state, stack stays invisible
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
      if (wb_adr_i == OFS_PCL) begin
        dat_r <= {24'h000000, pc_r[7:0]}; // RULE9
      end else if (wb_adr_i == OFS_ACC) begin
        dat_r <= {24'h000000, acc_r};
      end else if (wb_adr_i == OFS_STAT) begin
        dat_r <= {24'h000000, dummy_r, pend_r, flags_r};
      end else if (wb_adr_i == OFS_CTRL) begin
        dat_r <= {24'h000000, ctrl_r};
      end else begin
        dat_r <= 32'h0000_0000;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign pmem_addr = pc_r;
  // Strobe cycle keeps the old target; the next instruction is already in ir_r then
  assign data_addr = we_r ? waddr_r : ir_r[7:0];
  assign data_wdata = wdata_r;
  assign data_we = we_r;
  assign int_ack = iack_r;
  assign instruction_phase_clocks = phase_oh_r;
  assign oscillator_output_pin = osc_r;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_phase_onehot: assert property (phase_oh_r == (4'h1 << phase_r)) // RULE1
    else $error("phase clocks disagree with phase count");
  a_cycle_len: assert property (cycle_end |=> !cycle_end [*3] ##1 cycle_end) // RULE1
    else $error("instruction cycle is not four clocks");
  a_osc_duty: assert property ($rose(oscillator_output_pin) |=> !oscillator_output_pin [*3]) // RULE4
    else $error("oscillator pin duty is not 1:3");
  a_pc_step: assert property (exec && !branch && !skip && !take_irq |=> pc_r == $past(pc_r) + PC_ONE) // RULE5
    else $error("counter did not advance by one");
  a_branch_dummy: assert property (branch |=> dummy_r && pc_r == $past(target) ##4 !dummy_r) // RULE3
    else $error("branch without single dummy cycle");
  a_pcl_page: assert property (branch && (pcl_instr || pcl_take) |=> pc_r[11:8] == $past(pc_r[11:8])) // RULE6
    else $error("low byte write left the page");
  a_skip_two: assert property (skip |=> dummy_r ##4 pc_r == $past(pc_r, 5) + 12'h002) // RULE8
    else $error("skip did not move counter by two");
  a_irq_vector: assert property (take_irq |=> int_ack && pc_r == $past(vector)) // RULE15
    else $error("interrupt vector not loaded");
  a_full_hold: assert property (full && pend_r != 3'h0 |=> !int_ack) // RULE13
    else $error("acknowledge given with full stack");
  a_push_level: assert property (push && !full |=> stack_index == $past(stack_index) + SP_ONE) // RULE10
    else $error("push did not take a level");
  a_full_call: assert property (push && full |=> full && stack_r[DEPTH-1] == $past(pc_r)) // RULE14
    else $error("call on full stack did not overflow the top level");
  a_ret_load: assert property (pop && stack_index != '0 |=> pc_r == $past(pop_val)) // RULE11
    else $error("return did not restore counter");
  a_add_carry: assert property (exec && cls == CLS_ALU && op == ALU_ADD && !dest_mem // RULE17
    |=> {flags_r.c, acc_r} == {1'b0, $past(acc_r)} + {1'b0, $past(imm)})
    else $error("add result or carry wrong");
endmodule : ps_sequencer

//--- ps_pkg.sv
package ps_pkg;
  // Program counter vectors, counter step and stack depth
  localparam logic [11:0] VEC_RESET = 12'h000;
  localparam logic [11:0] VEC_EXT = 12'h004;
  localparam logic [11:0] VEC_T0 = 12'h008;
  localparam logic [11:0] VEC_T1 = 12'h00C;
  localparam logic [11:0] PC_ONE = 12'h001;
  localparam int STACK_LEVELS = 6;
  // Register byte offsets
  localparam logic [7:0] OFS_PCL = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h01;
  // Control bit positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_RCSEL = 1;
  localparam int CTRL_GIE = 2;
  localparam int CTRL_EN_LO = 3;
  localparam int CTRL_EN_HI = 5;
  // Instruction fields
  localparam int F_CLS_HI = 14;
  localparam int F_CLS_LO = 13;
  localparam int F_DEST = 12;
  localparam int F_OP_HI = 11;
  localparam int F_OP_LO = 8;
  localparam logic [1:0] CLS_ALU = 2'h0;
  localparam logic [1:0] CLS_JMP = 2'h1;
  localparam logic [1:0] CLS_CALL = 2'h2;
  localparam logic [1:0] CLS_CTRL = 2'h3;
  localparam logic [2:0] SUB_NOP = 3'h0;
  localparam logic [2:0] SUB_RET = 3'h1;
  localparam logic [2:0] SUB_INTERRUPT_RETURN_OP = 3'h2;
  localparam logic [2:0] SUB_SZ = 3'h3;
  localparam logic [2:0] SUB_SNZ = 3'h4;
  localparam logic [2:0] SUB_PCL = 3'h5;
  localparam logic [2:0] SUB_PCLA = 3'h6;
  // Decimal adjust figures
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [7:0] BCD_LO = 8'h06;
  localparam logic [7:0] BCD_HI = 8'h60;

  typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} ps_phase_type;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DAA, ALU_AND, ALU_OR, ALU_XOR,
    ALU_CPL, ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC, ALU_DEC, ALU_MOV
  } ps_alu_op_type;

  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } ps_flags_type;
endpackage : ps_pkg

//--- ps_pmem_model.sv
`timescale 1ns/1ps
module ps_pmem_model
  import ps_pkg::*;
(
  input wire logic clock,
  input wire logic [11:0] pmem_addr,
  output logic [14:0] pmem_data,
  input wire logic [7:0] data_addr,
  output logic [7:0] data_rdata,
  input wire logic [7:0] data_wdata,
  input wire logic data_we,
  output logic irq_ext,
  output logic irq_t0,
  output logic irq_t1
);
  logic [14:0] mem [0:4095];
  logic [7:0] ram [0:255];

  // Test image; every unlisted word is a no-operation so stray fetches stay harmless
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = {CLS_CTRL, 2'h0, SUB_NOP, 8'h00};
    for (int i = 0; i < 256; i++) ram[i] = 8'h00;
    mem[12'h000] = {CLS_ALU, 1'b0, 4'hF, 8'h00};
    mem[12'h001] = {CLS_CTRL, 2'h0, SUB_SZ, 8'h00};
    mem[12'h002] = {CLS_JMP, 1'b0, 12'h7FF}; // Must be skipped
    mem[12'h003] = {CLS_CALL, 1'b0, 12'h040};
    mem[12'h004] = {CLS_JMP, 1'b0, 12'h150};
    mem[12'h00C] = {CLS_ALU, 1'b1, 4'hD, 8'h20}; // Handler bumps a data byte
    mem[12'h00D] = {CLS_CTRL, 2'h0, SUB_INTERRUPT_RETURN_OP, 8'h00};
    // Six nested calls fill the stack; the call at 1AB then overflows it on every pass
    mem[12'h190] = {CLS_CALL, 1'b0, 12'h1A0};
    for (int i = 0; i < 5; i++) mem[12'h1A0 + 12'(2 * i)] = {CLS_CALL, 1'b0, 12'h1A2 + 12'(2 * i)};
    mem[12'h1AB] = {CLS_CALL, 1'b0, 12'h1AA};
    mem[12'h1B0] = {CLS_CTRL, 2'h0, SUB_RET, 8'h00};
    mem[12'h040] = {CLS_CTRL, 2'h0, SUB_RET, 8'h00};
    mem[12'h150] = {CLS_ALU, 1'b0, 4'hF, 8'h38};
    mem[12'h151] = {CLS_ALU, 1'b0, 4'h0, 8'h25};
    mem[12'h152] = {CLS_CTRL, 2'h0, SUB_PCL, 8'h80};
    mem[12'h180] = {CLS_CTRL, 2'h0, SUB_SNZ, 8'h00};
    mem[12'h181] = {CLS_JMP, 1'b0, 12'h7FF}; // Must be skipped
    mem[12'h183] = {CLS_JMP, 1'b0, 12'h182}; // Idle loop with one plain cycle
    {irq_t1, irq_t0, irq_ext} = 3'h0;
  end

  // Memories answer combinationally, as the fetch path expects
  assign pmem_data = mem[pmem_addr];
  assign data_rdata = ram[data_addr];

  // Data writes land on the strobe edge
  always @(posedge clock) begin
    if (data_we) ram[data_addr] <= data_wdata;
  end

  // One-clock request pulse; the sequencer must latch it itself
  task pulse_irq(input logic [2:0] lines);
    @(posedge clock);
    {irq_t1, irq_t0, irq_ext} <= lines;
    @(posedge clock);
    {irq_t1, irq_t0, irq_ext} <= 3'h0;
  endtask : pulse_irq
endmodule : ps_pmem_model

//--- testbench.sv
`timescale 1ns/1ps
module testbench
  import ps_pkg::*;
;
  logic clock, rst_n, wb_cyc, wb_stb, wb_we, wb_ack, data_we, int_ack, osc_pin;
  logic irq_ext, irq_t0, irq_t1;
  logic [7:0] wb_adr, data_addr, data_rdata, data_wdata, rd;
  logic [3:0] wb_sel, phases;
  logic [31:0] wb_dat_w, wb_dat_r;
  logic [11:0] pmem_addr;
  logic [14:0] pmem_data;
  logic [11:0] trace [$];
  logic [11:0] exp_trace [18] = '{12'h001, 12'h002, 12'h003, 12'h004, 12'h040, 12'h041, 12'h004, 12'h005,
    12'h150, 12'h151, 12'h152, 12'h153, 12'h180, 12'h181, 12'h182, 12'h183, 12'h184, 12'h182};
  int fails, cmp_count, cycles, n, acks;

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  ps_sequencer #(.DEPTH(STACK_LEVELS)) uut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
    .wb_ack_o(wb_ack), .pmem_addr(pmem_addr), .pmem_data(pmem_data), .data_addr(data_addr),
    .data_rdata(data_rdata), .data_wdata(data_wdata), .data_we(data_we), .irq_ext(irq_ext), .irq_t0(irq_t0),
    .irq_t1(irq_t1), .int_ack(int_ack), .instruction_phase_clocks(phases), .oscillator_output_pin(osc_pin));

  ps_pmem_model pm (.clock(clock), .pmem_addr(pmem_addr), .pmem_data(pmem_data), .data_addr(data_addr),
    .data_rdata(data_rdata), .data_wdata(data_wdata), .data_we(data_we), .irq_ext(irq_ext), .irq_t0(irq_t0),
    .irq_t1(irq_t1));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Classic single cycle; request held until ack is sampled, given up as a failure after 20 clocks
  task wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] dat);
    int k;
    @(posedge clock);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_w <= {24'h0, dat};
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (wb_ack !== 1'b1 && k < 20);
    if (k == 20) fails++;
    rd = wb_dat_r[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb_xfer

  // Phases must rotate one-hot; the pin follows phase one only when selected
  task phase_walk(input logic rc);
    logic [3:0] prev;
    @(posedge clock);
    #1;
    prev = phases;
    check(32'($countones(prev)), 32'h1);
    for (int k = 0; k < 8; k++) begin
      @(posedge clock);
      #1;
      check(32'(phases), 32'({prev[2:0], prev[3]}));
      check(32'(osc_pin), 32'(rc & phases[0]));
      prev = phases;
    end
  endtask : phase_walk

  task wrap_up();
    $display("Summary: %0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  // Fetch address just after each of the first 18 cycle ends, covering dummies too
  always begin
    @(posedge clock);
    if (rst_n === 1'b1 && phases === 4'h8 && trace.size() < 18) begin
      #1;
      trace.push_back(pmem_addr);
    end
  end

  // Acknowledge pulses, counted so a withheld one shows up
  always @(posedge clock) begin
    if (int_ack === 1'b1) acks++;
  end

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      wrap_up();
    end
  end

  initial begin
    {rst_n, wb_cyc, wb_stb, wb_we} = 4'h0;
    {wb_adr, wb_dat_w, wb_sel} = {8'h00, 32'h0, 4'h1};
    {fails, cmp_count, cycles, acks} = {32'd0, 32'd0, 32'd0, 32'd0};
    repeat (2) @(posedge clock);
    check(32'(pmem_addr), 32'h0);
    rst_n <= 1'b1;
    wb_xfer(1'b0, OFS_CTRL, 8'h00);
    check(32'(rd), 32'(CTRL_RST));
    wb_xfer(1'b0, 8'h10, 8'h00);
    check(32'(rd), 32'h0);
    $display("Test bus_reset done");
    n = 0;
    while (trace.size() < 18 && n < 200) begin
      @(posedge clock);
      n++;
    end
    check(32'(trace.size()), 32'd18);
    foreach (trace[i]) check(32'(trace[i]), 32'(exp_trace[i]));
    $display("Test program_flow done");
    wb_xfer(1'b0, OFS_ACC, 8'h00);
    check(32'(rd), 32'h5D);
    wb_xfer(1'b0, OFS_STAT, 8'h00);
    check(32'(rd[3:0]), 32'h0);
    wb_xfer(1'b0, OFS_PCL, 8'h00);
    check(32'(rd >= 8'h82 && rd <= 8'h84), 32'h1);
    $display("Test alu_and_low_byte done");
    phase_walk(1'b0);
    wb_xfer(1'b1, OFS_CTRL, 8'h03);
    phase_walk(1'b1);
    $display("Test phases done");
    wb_xfer(1'b1, OFS_CTRL, 8'h25);
    pm.pulse_irq(3'b101);
    n = 0;
    while (int_ack !== 1'b1 && n < 60) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(32'(int_ack), 32'h1);
    check(32'(pmem_addr), 32'(VEC_T1));
    wb_xfer(1'b0, OFS_STAT, 8'h00);
    check(32'(rd[6:4]), 32'h1);
    repeat (24) @(posedge clock);
    #1;
    check(32'(pmem_addr[11:8]), 32'h1);
    check(32'(pm.ram[8'h20]), 32'h1);
    $display("Test interrupt done");
    // Branch into the call chain, fill the stack, then raise an enabled request
    wb_xfer(1'b1, OFS_PCL, 8'h90);
    repeat (100) @(posedge clock);
    pm.pulse_irq(3'b100);
    repeat (40) @(posedge clock);
    #1;
    check(32'(acks), 32'h1);
    check(32'(pmem_addr[11:4]), 32'h1A);
    wb_xfer(1'b0, OFS_STAT, 8'h00);
    check(32'(rd[6:4]), 32'h5);
    // A return frees a level, so the held request must now be served
    wb_xfer(1'b1, OFS_PCL, 8'hB0);
    n = 0;
    while (int_ack !== 1'b1 && n < 60) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(32'(int_ack), 32'h1);
    check(32'(pmem_addr), 32'(VEC_T1));
    repeat (24) @(posedge clock);
    check(32'(pm.ram[8'h20]), 32'h2);
    $display("Test full_stack done");
    wrap_up();
  end
endmodule : testbench
